// file: bod_consts.svh
// Purpose: Offsets, field positions, reset values and fixed addresses of the byte-op decoder
// Assumes: Included by the decoder module only
// Notes:   Byte addresses on a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef BOD_CONSTS_SVH
`define BOD_CONSTS_SVH

// Register byte offsets
`define BOD_OFF_INSTR    8'h00
`define BOD_OFF_FILE_IN  8'h04
`define BOD_OFF_ACC      8'h08
`define BOD_OFF_BANK     8'h0c
`define BOD_OFF_STATUS   8'h10
`define BOD_OFF_RESULT   8'h14
`define BOD_OFF_PRODUCT  8'h18
`define BOD_OFF_MOVE     8'h1c
`define BOD_OFF_TARGET   8'h20
`define BOD_OFF_DECODE   8'h24
`define BOD_OFF_CTRL     8'h28

// Status flag positions
`define BOD_FLAG_C       0
`define BOD_FLAG_DIGIT_CARRY 1
`define BOD_FLAG_Z       2
`define BOD_FLAG_OVERFLOW 3
`define BOD_FLAG_N       4

// Reset values
`define BOD_RST_ACC      8'h00
`define BOD_RST_BANK     4'h0
`define BOD_RST_FLAGS    5'h00

// Fixed file addresses of the surrounding core
`define BOD_ACCESS_SPLIT 8'h60
`define BOD_PORT_FIRST   12'hf80
`define BOD_PORT_LAST    12'hf84
`define BOD_TIMER_ADDR   12'hfd6

// Bus responses
`define BOD_RESP_OKAY    2'b00
`define BOD_RESP_SLVERR  2'b10

`endif

// file: bod_pkg.sv
// Purpose: Types of the byte-op decoder
// Assumes: Nothing beyond the constants header
// Notes:   All decoder state is one packed struct
package bod_pkg;

	// Word-sequencing phase
	typedef enum logic [1:0] {
		BOD_FIRST,
		BOD_SECOND,
		BOD_SKIP,
		BOD_SKIP2
	} bod_phase_t;

	// Whole module state
	typedef struct packed {
		logic             aw_have;
		logic [7:0]       aw_addr;
		logic             w_have;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [7:0]       acc;
		logic [3:0]       bank;
		logic [4:0]       flags;
		logic [15:0]      file_in;
		logic             presc_assigned;
		logic [15:0]      instr;
		bod_phase_t       phase;
		logic [15:0]      first;
		logic [7:0]       res;
		logic             file_wr;
		logic             acc_wr;
		logic             skip;
		logic [1:0]       cycles;
		logic             presc_clr;
		logic [11:0]      eaddr;
		logic [15:0]      prod;
		logic [11:0]      mov_src;
		logic [11:0]      mov_dst;
		logic [19:0]      target;
		logic             fast;
	} bod_state_t;

endpackage : bod_pkg

// file: bod_decoder.sv
// Purpose: Decode and execute byte-oriented file operations of an 8-bit accumulator core
// Assumes: Software supplies file and pin values, then writes an instruction word
// Notes:   Rules carried out by this block are listed below
// Function
// - Destination bit picks accumulator or file
// - Access bit picks fixed bank or bank register
// - File address is low instruction byte
// - Two-word move carries 12-bit source, destination
// - Bit ops carry 3-bit position field
// - Literal is low byte immediate
// - Call/goto target 20 bits over two words
// - Add and add-with-carry, all five flags
// - OR, AND, XOR, complement: zero, negative only
// - Compare with accumulator skips, no flags
// - Counting skips change no flags
// - Unsigned multiply, no flags changed
// - Rotates through carry: carry, zero, negative
// - Plain rotates: zero and negative only
// - Subtractions update all five flags
// - Port operand read from pin levels
// - Timer write clears assigned prescaler
// - PC change or true test: two cycles
// - Second word nop; skipped two-word: three cycles
// - Product split into high, low bytes
// - Five arithmetic status flags kept
`timescale 1ns/100ps
`include "bod_consts.svh"

module bod_decoder
	import bod_pkg::*;
(
	input  wire logic        aclk,    // 25 MHz clock
	input  wire logic        aresetn, // Sync reset, active low
	input  wire logic [7:0]  awaddr,  // Write address
	input  wire logic [2:0]  awprot,  // Unused protection
	input  wire logic        awvalid, // Write address valid
	output logic             awready, // Write address ready
	input  wire logic [31:0] wdata,   // Write data
	input  wire logic [3:0]  wstrb,   // Byte strobes
	input  wire logic        wvalid,  // Write data valid
	output logic             wready,  // Write data ready
	output logic [1:0]       bresp,   // Write response
	output logic             bvalid,  // Write response valid
	input  wire logic        bready,  // Write response ready
	input  wire logic [7:0]  araddr,  // Read address
	input  wire logic [2:0]  arprot,  // Unused protection
	input  wire logic        arvalid, // Read address valid
	output logic             arready, // Read address ready
	output logic [31:0]      rdata,   // Read data
	output logic [1:0]       rresp,   // Read response
	output logic             rvalid,  // Read data valid
	input  wire logic        rready   // Read data ready
);

	bod_state_t  s_q;        // Registered state
	bod_state_t  s_d;        // Next state
	logic [15:0] iw;         // Word being issued
	logic [11:0] ea;         // Effective file address
	logic [7:0]  fv;         // File operand
	logic [7:0]  res;        // Operation result
	logic [4:0]  fl;         // Flags after operation
	logic        wr;         // Result is written
	logic        to_file;    // Result goes to file
	logic        skip;       // Conditional test true
	logic        two_word;   // Word opens a two-word op
	logic        mul;        // Multiply issued
	logic [12:0] ar;         // Adder output, flags and sum
	logic [31:0] merged;     // Strobe-merged write word
	logic [32:0] wa;         // Addressed register before the write
	logic [32:0] rd;         // Read hit and data

	// Byte-lane merge, used for every writable register except the control register
	function automatic logic [31:0] bod_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			bod_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction : bod_merge

	// Adder with carry in; subtraction passes the inverted operand and carry as not-borrow
	function automatic logic [12:0] bod_add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] s;
		logic [4:0] lo;
		logic [4:0] f;
		s                = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		lo               = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		f[`BOD_FLAG_C]   = s[8];
		f[`BOD_FLAG_DIGIT_CARRY] = lo[4];
		f[`BOD_FLAG_Z]   = (s[7:0] == 8'h00);
		f[`BOD_FLAG_OVERFLOW] = (a[7] == b[7]) && (s[7] != a[7]);
		f[`BOD_FLAG_N]   = s[7];
		return {f, s[7:0]};
	endfunction : bod_add8

	// Access bit and bank register form the 12-bit file address
	function automatic logic [11:0] bod_eaddr(input logic a, input logic [7:0] f,
		input logic [3:0] bank);
		if (a)
			return {bank, f};
		else if (f < `BOD_ACCESS_SPLIT)
			return {4'h0, f};
		else
			return {4'hf, f};
	endfunction : bod_eaddr

	// Does this word open a two-word instruction
	function automatic logic bod_is_two(input logic [15:0] w);
		return (w[15:12] == 4'hc) || (w[15:9] == 7'b1110_110) || (w[15:8] == 8'hef);
	endfunction : bod_is_two

	// Register read decode; the top bit says the offset is mapped
	function automatic logic [32:0] bod_read(input logic [7:0] a, input bod_state_t s);
		case (a)
			`BOD_OFF_INSTR:   return {1'b1, 16'h0000, s.instr};
			`BOD_OFF_FILE_IN: return {1'b1, 16'h0000, s.file_in};
			`BOD_OFF_ACC:     return {1'b1, 24'h000000, s.acc};
			`BOD_OFF_BANK:    return {1'b1, 28'h0000000, s.bank};
			`BOD_OFF_STATUS:  return {1'b1, 27'h0000000, s.flags};
			`BOD_OFF_RESULT:  return {1'b1, 3'h0, s.eaddr, 1'b0, s.presc_clr, s.cycles,
				s.phase, s.skip, s.acc_wr, s.file_wr, s.res};
			`BOD_OFF_PRODUCT: return {1'b1, 16'h0000, s.prod};
			`BOD_OFF_MOVE:    return {1'b1, 4'h0, s.mov_dst, 4'h0, s.mov_src};
			`BOD_OFF_TARGET:  return {1'b1, 11'h000, s.fast, s.target};
			`BOD_OFF_DECODE:  return {1'b1, 16'h0, s.instr[7:0], 5'h0, s.instr[11:9]};
			`BOD_OFF_CTRL:    return {1'b1, 31'h00000000, s.presc_assigned};
			default:          return {1'b0, 32'h00000000};
		endcase
	endfunction : bod_read

	// Pending write merged over the addressed register; for the instruction
	// register this is the word being issued
	assign wa     = bod_read(s_q.aw_addr, s_q);
	assign merged = bod_merge(wa[31:0], s_q.wdata, s_q.wstrb);
	assign iw     = merged[15:0];

	// Datapath: operand fetch, operation, flags, skip test
	always_comb
	begin
		ea       = bod_eaddr(iw[8], iw[7:0], s_q.bank);
		// Port reads see the pins, not the output latch
		if (ea >= `BOD_PORT_FIRST && ea <= `BOD_PORT_LAST)
			fv = s_q.file_in[15:8];
		else
			fv = s_q.file_in[7:0];
		res      = fv;
		fl       = s_q.flags;
		wr       = 1'b0;
		to_file  = iw[9];
		skip     = 1'b0;
		mul      = 1'b0;
		ar       = 13'h0000;
		two_word = bod_is_two(iw);
		unique casez (iw[15:10])
			6'b0000_00:
			begin
				// Multiply word; the other codes here are core controls
				mul = iw[9];
			end
			6'b0000_01:
			begin
				ar  = bod_add8(fv, 8'hfe, 1'b1);
				res = ar[7:0];
				fl  = ar[12:8];
				wr  = 1'b1;
			end
			6'b0010_01, 6'b0010_00:
			begin
				// Carry-in only for the with-carry form
				ar  = bod_add8(s_q.acc, fv, iw[10] ? 1'b0 : s_q.flags[`BOD_FLAG_C]);
				res = ar[7:0];
				fl  = ar[12:8];
				wr  = 1'b1;
			end
			6'b0010_10:
			begin
				ar  = bod_add8(fv, 8'h01, 1'b0);
				res = ar[7:0];
				fl  = ar[12:8];
				wr  = 1'b1;
			end
			6'b0001_??:
			begin
				unique case (iw[11:10])
					2'b00:   res = s_q.acc | fv;
					2'b01:   res = s_q.acc & fv;
					2'b10:   res = s_q.acc ^ fv;
					default: res = ~fv;
				endcase
				fl[`BOD_FLAG_Z] = (res == 8'h00);
				fl[`BOD_FLAG_N] = res[7];
				wr              = 1'b1;
			end
			6'b0010_11, 6'b0011_11, 6'b0100_11, 6'b0100_10:
			begin
				// Count then skip on zero or nonzero, flags untouched
				// Decrement for 0010 11 and 0100 11, increment for 0011 11 and 0100 10
				res  = (iw[13] ? !iw[12] : iw[10]) ? fv - 8'h01 : fv + 8'h01;
				skip = (iw[15:12] == 4'h4) ? (res != 8'h00) : (res == 8'h00);
				wr   = 1'b1;
			end
			6'b0011_01, 6'b0011_00:
			begin
				res = iw[10] ? {fv[6:0], s_q.flags[`BOD_FLAG_C]} : {s_q.flags[`BOD_FLAG_C], fv[7:1]};
				fl[`BOD_FLAG_C] = iw[10] ? fv[7] : fv[0];
				fl[`BOD_FLAG_Z] = (res == 8'h00);
				fl[`BOD_FLAG_N] = res[7];
				wr              = 1'b1;
			end
			6'b0011_10:
			begin
				res = {fv[3:0], fv[7:4]};
				wr  = 1'b1;
			end
			6'b0100_01, 6'b0100_00:
			begin
				res = iw[10] ? {fv[6:0], fv[7]} : {fv[0], fv[7:1]};
				fl[`BOD_FLAG_Z] = (res == 8'h00);
				fl[`BOD_FLAG_N] = res[7];
				wr              = 1'b1;
			end
			6'b0101_00:
			begin
				fl[`BOD_FLAG_Z] = (fv == 8'h00);
				fl[`BOD_FLAG_N] = fv[7];
				wr              = 1'b1;
			end
			6'b0101_01, 6'b0101_10, 6'b0101_11:
			begin
				// Borrow enters as inverted carry; plain form has no borrow
				if (iw[11:10] == 2'b01)
					ar = bod_add8(s_q.acc, ~fv, s_q.flags[`BOD_FLAG_C]);
				else
					ar = bod_add8(fv, ~s_q.acc, iw[10] | s_q.flags[`BOD_FLAG_C]);
				res = ar[7:0];
				fl  = ar[12:8];
				wr  = 1'b1;
			end
			6'b0110_??:
			begin
				// Compares and tests never write; the rest always go to file
				to_file = 1'b1;
				unique case (iw[11:9])
					3'b000:  skip = fv < s_q.acc;
					3'b001:  skip = fv == s_q.acc;
					3'b010:  skip = fv > s_q.acc;
					3'b011:  skip = fv == 8'h00;
					3'b100:
					begin
						res = 8'hff;
						wr  = 1'b1;
					end
					3'b101:
					begin
						res             = 8'h00;
						fl[`BOD_FLAG_Z] = 1'b1;
						wr              = 1'b1;
					end
					3'b110:
					begin
						ar  = bod_add8(8'h00, ~fv, 1'b1);
						res = ar[7:0];
						fl  = ar[12:8];
						wr  = 1'b1;
					end
					default:
					begin
						res = s_q.acc;
						wr  = 1'b1;
					end
				endcase
			end
			6'b0111_??, 6'b100?_??, 6'b101?_??:
			begin
				// Bit field selects one bit of the file byte
				to_file = 1'b1;
				unique case (iw[15:12])
					4'h7:    res[iw[11:9]] = ~fv[iw[11:9]];
					4'h8:    res[iw[11:9]] = 1'b1;
					4'h9:    res[iw[11:9]] = 1'b0;
					4'ha:    skip = fv[iw[11:9]];
					default: skip = ~fv[iw[11:9]];
				endcase
				wr = !iw[15] || (iw[14:13] == 2'b00); // Bit tests never write
			end
			default:
			begin
				// Literal, branch and unassigned words change nothing here
				wr = 1'b0;
			end
		endcase
	end

	// Bus slave, instruction sequencing and register updates
	always_comb
	begin
		s_d = s_q;
		rd  = bod_read(araddr, s_q);
		// Read channel: one outstanding read, answered next cycle
		if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;
		if (arvalid && !s_q.rvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = rd[31:0];
			s_d.rresp  = rd[32] ? `BOD_RESP_OKAY : `BOD_RESP_SLVERR;
		end
		// Write channel: address and data taken in either order
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;
		if (awvalid && awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata  = wdata;
			s_d.wstrb  = wstrb;
		end
		if (s_q.aw_have && s_q.w_have)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = wa[32] ? `BOD_RESP_OKAY : `BOD_RESP_SLVERR;
			unique case (s_q.aw_addr)
				`BOD_OFF_FILE_IN: s_d.file_in = merged[15:0];
				`BOD_OFF_ACC:     s_d.acc     = merged[7:0];
				`BOD_OFF_BANK:    s_d.bank    = merged[3:0];
				`BOD_OFF_STATUS:  s_d.flags   = merged[4:0];
				`BOD_OFF_CTRL:    s_d.presc_assigned = s_q.wstrb[0] ? s_q.wdata[0] : s_q.presc_assigned;
				`BOD_OFF_INSTR:
				begin
					s_d.instr = iw;
					unique case (s_q.phase)
						BOD_SKIP, BOD_SKIP2:
						begin
							// Skipped word is flushed as a nop, one cycle each
							s_d.cycles = s_q.cycles + 2'd1;
							s_d.phase  = (s_q.phase == BOD_SKIP && two_word) ? BOD_SKIP2 : BOD_FIRST;
						end
						BOD_SECOND:
						begin
							if (iw[15:12] == 4'hf)
							begin
								// Second word consumed by its opener
								s_d.phase  = BOD_FIRST;
								s_d.cycles = 2'd2;
								if (s_q.first[15:12] == 4'hc)
								begin
									s_d.mov_src = s_q.first[11:0];
									s_d.mov_dst = iw[11:0];
								end
								else
								begin
									s_d.target = {iw[11:0], s_q.first[7:0]};
									s_d.fast   = (s_q.first[15:9] == 7'b1110_110) & s_q.first[8];
								end
							end
							else
								s_d.phase = BOD_FIRST; // Opener abandoned, word dropped
						end
						default:
						begin
							s_d.file_wr   = 1'b0;
							s_d.acc_wr    = 1'b0;
							s_d.skip      = 1'b0;
							s_d.presc_clr = 1'b0;
							s_d.cycles    = 2'd1;
							s_d.eaddr     = ea;
							s_d.res       = res;
							if (iw[15:12] == 4'hf)
								s_d.cycles = 2'd1; // Orphan second word is a nop
							else if (two_word)
							begin
								s_d.first = iw;
								s_d.phase = BOD_SECOND;
							end
							else
							begin
								s_d.flags = fl;
								s_d.skip  = skip;
								if (skip)
								begin
									s_d.phase  = BOD_SKIP;
								end
								if (mul)
									s_d.prod = {8'h00, s_q.acc} * {8'h00, fv};
								if (wr && !to_file)
								begin
									s_d.acc    = res;
									s_d.acc_wr = 1'b1;
								end
								if (wr && to_file)
								begin
									s_d.file_wr   = 1'b1;
									s_d.presc_clr = (ea == `BOD_TIMER_ADDR) && s_q.presc_assigned;
								end
							end
						end
					endcase
				end
				default: s_d.bresp = s_d.bresp; // Read-only or unmapped: no store
			endcase
		end
	end

	// Handshake outputs from state
	assign awready = !s_q.aw_have && !s_q.bvalid;
	assign wready  = !s_q.w_have && !s_q.bvalid;
	assign arready = !s_q.rvalid;
	assign bvalid  = s_q.bvalid;
	assign bresp   = s_q.bresp;
	assign rvalid  = s_q.rvalid;
	assign rdata   = s_q.rdata;
	assign rresp   = s_q.rresp;

	// State register; reset leaves accumulator, bank and flags cleared
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q       <= '0;
			s_q.acc   <= `BOD_RST_ACC;
			s_q.bank  <= `BOD_RST_BANK;
			s_q.flags <= `BOD_RST_FLAGS;
			s_q.phase <= BOD_FIRST;
		end
		else
			s_q <= s_d;
	end

endmodule : bod_decoder

// file: bod_decoder_sva.sv
// Purpose: Bus protocol checks on the byte-op decoder ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every decoder instance below
`timescale 1ns/100ps
module bod_decoder_sva (
	input wire logic        aclk,    // Clock
	input wire logic        aresetn, // Reset, active low
	input wire logic        awvalid, // Write address valid
	input wire logic        awready, // Write address ready
	input wire logic        wvalid,  // Write data valid
	input wire logic        wready,  // Write data ready
	input wire logic [1:0]  bresp,   // Write response
	input wire logic        bvalid,  // Write response valid
	input wire logic        bready,  // Write response ready
	input wire logic [7:0]  araddr,  // Read address
	input wire logic        arvalid, // Read address valid
	input wire logic        arready, // Read address ready
	input wire logic [31:0] rdata,   // Read data
	input wire logic [1:0]  rresp,   // Read response
	input wire logic        rvalid,  // Read data valid
	input wire logic        rready   // Read data ready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Answers stand until the master takes them
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped early");
	// Answers leave once taken
	b_drop_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write response repeated");
	r_drop_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read data repeated");
	// Read answers one cycle after the address, write within two
	read_ans_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	wr_ans_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	// No new request taken while an answer is pending
	w_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	ar_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while data pending");
	// Reads above offset 28 give an error and zero data
	unmap_rd_a: assert property (arvalid && arready && araddr > 8'h28
		|=> rresp == 2'b10 && rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule : bod_decoder_sva

bind bod_decoder bod_decoder_sva chk (.*);

// file: bod_decoder_tb.sv
// Purpose: Self-checking bench for the byte-op decoder over its register bus
// Assumes: Registers and timing as in the decoder hand-over
// Notes:   Model of the file operations is integer arithmetic in the bench
`timescale 1ns/100ps
module bod_decoder_tb;
	logic        aclk = 0;       // Clock
	logic        aresetn = 0;    // Reset
	logic [7:0]  awaddr = 0;     // Write address
	logic        awvalid = 0;    // Write address valid
	logic        awready;        // Write address ready
	logic [31:0] wdata = 0;      // Write data
	logic        wvalid = 0;     // Write data valid
	logic        wready;         // Write data ready
	logic [1:0]  bresp;          // Write response
	logic        bvalid;         // Write response valid
	logic        bready = 0;     // Write response ready
	logic [7:0]  araddr = 0;     // Read address
	logic        arvalid = 0;    // Read address valid
	logic        arready;        // Read address ready
	logic [31:0] rdata;          // Read data
	logic [1:0]  rresp;          // Read response
	logic        rvalid;         // Read data valid
	logic        rready = 0;     // Read data ready
	logic [31:0] rv, r, q;       // Read value, random words
	logic [1:0]  rr, br;         // Last responses
	logic [12:0] e;              // Model flags and result
	logic [11:0] ea;             // Expected effective address
	logic [7:0]  fa, opnd;       // File field, chosen operand
	logic        d, ab, pc;      // Destination, access bit, prescaler clear
	int          miscompares = 0;
	int          checked = 0;
	int          cyc = 0;
	// Byte operations under test
	logic [5:0] ops [13] = '{6'h09, 6'h08, 6'h05, 6'h04, 6'h06, 6'h07, 6'h0d, 6'h0c,
		6'h11, 6'h10, 6'h17, 6'h16, 6'h15};
	// Skip operations: opcode byte, file value, expected result
	logic [7:0] sk_op [7] = '{8'h60, 8'h62, 8'h64, 8'h2e, 8'h3e, 8'h4e, 8'h4a};
	logic [7:0] sk_f [7] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'hff, 8'h05, 8'h05};
	logic [7:0] sk_r [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h06};

	bod_decoder dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready)
	);

	always #20 aclk = ~aclk;

	// Hang guard; whole run needs under two thousand cycles
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			report_and_stop();
		end
	end

	// Result, flags of one file operation; C is not-borrow on subtracts
	function automatic logic [12:0] model(input logic [5:0] o, input logic [7:0] w, f,
		input logic [4:0] s);
		logic [7:0] a, b, t;
		logic       ci, ar;
		logic [8:0] sum;
		logic [4:0] n, lo;
		n = s;
		a = f;
		b = w;
		ci = 1'b0;
		ar = 1'b1;
		t = 8'h00;
		case (o)
			6'h08: ci = s[0];
			6'h17: {b, ci} = {~w, 1'b1};
			6'h16: {b, ci} = {~w, s[0]};
			6'h15: {a, b, ci} = {w, ~f, s[0]};
			6'h09: ar = 1'b1;
			default: ar = 1'b0;
		endcase
		case (o)
			6'h05: t = w & f;
			6'h04: t = w | f;
			6'h06: t = w ^ f;
			6'h07: t = ~f;
			6'h0d: {n[0], t} = {f, s[0]};
			6'h0c: {t, n[0]} = {s[0], f};
			6'h11: t = {f[6:0], f[7]};
			6'h10: t = {f[0], f[7:1]};
			default: t = 8'h00;
		endcase
		if (ar)
		begin
			sum = a + b + ci;
			lo = a[3:0] + b[3:0] + ci;
			t = sum[7:0];
			n[0] = sum[8];
			n[1] = lo[4];
			n[3] = (a[7] == b[7]) && (t[7] != a[7]);
		end
		n[2] = (t == 8'h00);
		n[4] = t[7];
		return {n, t};
	endfunction : model

	// Word comparison
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, g, x);
		end
	endtask : chk

	// Bus response comparison
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
		checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t response %b expected %b", $time, g, x);
		end
	endtask : chk_resp

	// One write; ready sampled at the falling edge, acted on at the rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw, ta, tw, b;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		b = 1'b0;
		while (pa || pw)
		begin
			@(negedge aclk);
			ta = awready && pa;
			tw = wready && pw;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		bready <= 1'b1;
		while (!b)
		begin
			@(negedge aclk);
			b = bvalid;
			br = bresp;
			@(posedge aclk);
		end
		bready <= 1'b0;
	endtask : wr

	// One read
	task automatic rd(input logic [7:0] a);
		logic t;
		araddr <= a;
		arvalid <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = rvalid;
			rv = rdata;
			rr = rresp;
			@(posedge aclk);
		end
		rready <= 1'b0;
	endtask : rd

	// Verdict
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	initial
	begin
		void'($urandom(32'ha9d04ecd));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values, unmapped places
		rd(8'h08); chk(rv, 32'h0);
		rd(8'h10); chk(rv, 32'h0);
		rd(8'h2c); chk_resp(rr, 2'b10);
		wr(8'h30, 32'h1); chk_resp(br, 2'b10);
		$display("test bus done");
		// File operations; every third hits a port, every third the timer
		for (int i = 0; i < 65; i++)
		begin
			r = $urandom;
			q = $urandom;
			{d, ab, fa} = {r[21], r[22], r[15:8]};
			if (i % 3 == 0)
				{ab, fa} = {1'b0, 6'h20, q[9:8]};
			else if (i % 3 == 1)
				{ab, fa} = {1'b0, 8'hd6};
			ea = ab ? {r[26:23], fa} : (fa < 8'h60 ? {4'h0, fa} : {4'hf, fa});
			opnd = (ea >= 12'hf80 && ea <= 12'hf84) ? q[7:0] : q[15:8];
			pc = r[27] && d && ea == 12'hfd6;
			e = model(ops[i % 13], r[7:0], opnd, r[20:16]);
			wr(8'h04, {16'h0, q[7:0], q[15:8]});
			wr(8'h08, {24'h0, r[7:0]});
			wr(8'h0c, {28'h0, r[26:23]});
			wr(8'h10, {27'h0, r[20:16]});
			wr(8'h28, {31'h0, r[27]});
			wr(8'h00, {16'h0, ops[i % 13], d, ab, fa});
			rd(8'h14); chk({rv[28:17], rv[15], rv[12:0]}, {6'h0, ea, pc, 3'h0, ~d, d, e[7:0]});
			rd(8'h10); chk(rv, {27'h0, e[12:8]});
			rd(8'h08); chk(rv, {24'h0, d ? r[7:0] : e[7:0]});
		end
		$display("test file ops done");
		// True skips flush the next word and leave flags alone
		for (int i = 0; i < 7; i++)
		begin
			r = $urandom;
			wr(8'h08, 32'h2);
			wr(8'h04, {24'h0, sk_f[i]});
			wr(8'h10, {27'h0, r[4:0]});
			wr(8'h00, {16'h0, sk_op[i], 8'h10});
			rd(8'h14); chk({rv[12:10], i > 2 ? rv[7:0] : 8'h0}, {3'b101, i > 2 ? sk_r[i] : 8'h0});
			rd(8'h10); chk(rv, {27'h0, r[4:0]});
			wr(8'h00, 32'h2410);
			rd(8'h14); chk({30'h0, rv[14:13]}, 32'h2);
			rd(8'h08); chk(rv, 32'h2);
		end
		// Skip over a two-word word flushes both halves
		wr(8'h00, 32'h6410);
		wr(8'h00, 32'hc123);
		wr(8'h00, 32'hf456);
		rd(8'h14); chk({30'h0, rv[14:13]}, 32'h3);
		rd(8'h1c); chk(rv, 32'h0);
		$display("test skips done");
		// Multiply, then unassigned word
		r = $urandom;
		wr(8'h08, {24'h0, r[7:0]});
		wr(8'h04, {24'h0, r[15:8]});
		wr(8'h10, {27'h0, r[20:16]});
		wr(8'h00, 32'h0210);
		rd(8'h18); chk(rv, {16'h0, 16'(r[7:0]) * 16'(r[15:8])});
		rd(8'h10); chk(rv, {27'h0, r[20:16]});
		wr(8'h00, 32'h0001);
		rd(8'h08); chk(rv, {24'h0, r[7:0]});
		// Two-word move, goto and call
		wr(8'h00, {16'h0, 4'hc, r[11:0]});
		rd(8'h14); chk({30'h0, rv[12:11]}, 32'h1);
		wr(8'h00, {16'h0, 4'hf, r[23:12]});
		rd(8'h1c); chk(rv, {4'h0, r[23:12], 4'h0, r[11:0]});
		for (int j = 0; j < 2; j++)
		begin
			q = $urandom;
			wr(8'h00, {16'h0, j ? 8'hed : 8'hef, q[7:0]});
			wr(8'h00, {16'h0, 4'hf, q[19:8]});
			rd(8'h20); chk({11'h0, rv[20:0]}, {11'h0, j[0], q[19:0]});
		end
		// Bit position and literal fields
		wr(8'h00, {16'h0, 4'h9, r[2:0], 9'h010});
		rd(8'h24); chk({29'h0, rv[2:0]}, {29'h0, r[2:0]});
		wr(8'h00, {16'h0, 8'h0e, r[31:24]});
		rd(8'h24); chk({24'h0, rv[15:8]}, {24'h0, r[31:24]});
		$display("test formats done");
		report_and_stop();
	end
endmodule : bod_decoder_tb
